/* File: design/lcb_regs.vh */
// register map, field layout and timing constants of the light curtain blanking evaluator
//
// What this block does
// - fixed mode blanks one contiguous configured beam set; other beams stay normally evaluated
// - fixed mode accepts the configured count or one less, tolerance is global
// - fixed blanking configuration needs at least two adjacent beams, else rejected
// - fixed mode opens outputs on shifted or split interruptions
// - monitored floating: configured adjacent count always blocked anywhere in region, minus one
// - floating mode opens outputs when more than the configured count is blocked
// - unmonitored floating accepts zero to maximum blocked beams, any grouping
// - configurations with overlapping regions are refused
// - beams outside any blanking region get standard safety evaluation
// - blanking only takes effect while the blanking lamp is detected
// - red indicator led lights whenever blanking is configured
// - service link attached while unpowered gets configuration sent automatically at power-up
// - monitored floating allows a single neighbouring group; a second group opens outputs
// - defective or missing blanking lamp causes immediate lockout while blanking is configured
`ifndef LCB_REGS_VH
`define LCB_REGS_VH

`define LCB_NUM_BEAMS 60
`define LCB_NUM_REGIONS 4

// word offsets on the register port
`define LCB_OFF_CTRL 4'h0
`define LCB_OFF_STATUS 4'h1
`define LCB_OFF_BEAMS_LO 4'h2
`define LCB_OFF_BEAMS_HI 4'h3
`define LCB_OFF_REGION0 4'h4

// control bits
`define LCB_CTRL_COMMIT 0

// status bits
`define LCB_ST_CLOSED 0
`define LCB_ST_LOCKOUT 1
`define LCB_ST_CFG_ERR 2
`define LCB_ST_LAMP 3
`define LCB_ST_BLANK_CFG 4
`define LCB_ST_UPLOAD 5

// region word fields
`define LCB_RG_LO_MSB 5
`define LCB_RG_LO_LSB 0
`define LCB_RG_HI_MSB 13
`define LCB_RG_HI_LSB 8
`define LCB_RG_MODE_MSB 17
`define LCB_RG_MODE_LSB 16
`define LCB_RG_CNT_MSB 29
`define LCB_RG_CNT_LSB 24

// region modes
`define LCB_MODE_NONE 2'h0
`define LCB_MODE_FIXED 2'h1
`define LCB_MODE_FLOAT_MON 2'h2
`define LCB_MODE_FLOAT_FREE 2'h3

`define LCB_REGION_RESET 32'h00000000

// service link timing
`define LCB_CLK_HZ 100000000
`define LCB_LINK_BAUD 9600
`define LCB_UPLOAD_BYTES 16

`endif

/* File: design/lcb_blanking_eval.v */
// light curtain blanking evaluator with register port and power-up configuration upload
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "lcb_regs.vh"

module lcb_blanking_eval #(
  parameter BIT_CYCLES = `LCB_CLK_HZ / `LCB_LINK_BAUD
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // beam receiver array
  input wire [59:0] beam_blocked,
  input wire scan_done,
  // blanking lamp sense
  input wire lamp_present,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // safety side
  output reg safety_output_block_closed,
  output reg lockout,
  output reg blank_led_red,
  // optical service link
  input wire link_attached,
  output reg link_tx
);

  localparam UP_WAIT = 2'h0;
  localparam UP_CHECK = 2'h1;
  localparam UP_SEND = 2'h2;
  localparam UP_DONE = 2'h3;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [59:0] beam_sync;
  wire scan_sync;
  wire lamp_sync;
  wire link_sync;
  reg scan_dly_reg;
  wire scan_edge;

  lcb_sync2 #(.WIDTH(60)) i_beam_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(beam_blocked),
    .sync_out(beam_sync)
  );

  lcb_sync2 #(.WIDTH(1)) i_scan_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(scan_done),
    .sync_out(scan_sync)
  );

  lcb_sync2 #(.WIDTH(1)) i_lamp_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(lamp_present),
    .sync_out(lamp_sync)
  );

  lcb_sync2 #(.WIDTH(1)) i_link_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .async_in(link_attached),
    .sync_out(link_sync)
  );

  // the edge compares the settled level with its own delayed copy, never the first stage
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_dly_reg <= 1'b0;
    end else begin
      scan_dly_reg <= scan_sync;
    end
  end

  assign scan_edge = scan_sync & ~scan_dly_reg;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg [31:0] shadow_reg [0:3];
  reg [31:0] active_reg [0:3];
  reg cfg_err_reg;
  reg cfg_valid;
  reg [3:0] rg_on;
  integer r;
  integer s;
  integer k;

  // a new set only goes live when it passes every check
  always @* begin
    cfg_valid = 1'b1;
    rg_on = 4'h0;
    for (r = 0; r < 4; r = r + 1) begin
      rg_on[r] = shadow_reg[r][`LCB_RG_MODE_MSB:`LCB_RG_MODE_LSB] != `LCB_MODE_NONE;
      if (rg_on[r]) begin
        if (shadow_reg[r][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB] > shadow_reg[r][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB])
          cfg_valid = 1'b0;
        if (shadow_reg[r][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB] >= 6'd60)
          cfg_valid = 1'b0;
        if (shadow_reg[r][`LCB_RG_MODE_MSB:`LCB_RG_MODE_LSB] == `LCB_MODE_FIXED &&
            shadow_reg[r][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB] == shadow_reg[r][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB])
          cfg_valid = 1'b0;
        if (shadow_reg[r][`LCB_RG_MODE_MSB:`LCB_RG_MODE_LSB] == `LCB_MODE_FLOAT_MON &&
            shadow_reg[r][`LCB_RG_CNT_MSB:`LCB_RG_CNT_LSB] < 6'd2)
          cfg_valid = 1'b0;
        if (shadow_reg[r][`LCB_RG_MODE_MSB:`LCB_RG_MODE_LSB] != `LCB_MODE_FIXED &&
            shadow_reg[r][`LCB_RG_CNT_MSB:`LCB_RG_CNT_LSB] >
            shadow_reg[r][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB] - shadow_reg[r][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB] + 6'd1)
          cfg_valid = 1'b0;
      end
    end
    for (r = 0; r < 4; r = r + 1) begin
      for (s = r + 1; s < 4; s = s + 1) begin
        if (rg_on[r] && rg_on[s] &&
            !(shadow_reg[r][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB] < shadow_reg[s][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB] ||
              shadow_reg[s][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB] < shadow_reg[r][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB]))
          cfg_valid = 1'b0;
      end
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (k = 0; k < 4; k = k + 1) begin
        shadow_reg[k] <= `LCB_REGION_RESET;
        active_reg[k] <= `LCB_REGION_RESET;
      end
      cfg_err_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr >= `LCB_OFF_REGION0 && reg_addr < `LCB_OFF_REGION0 + 4'h4)
        shadow_reg[reg_addr[1:0]] <= reg_wdata & 32'h3f03_3f3f;
      if (reg_wr && reg_addr == `LCB_OFF_CTRL && reg_wdata[`LCB_CTRL_COMMIT]) begin
        cfg_err_reg <= ~cfg_valid;
        if (cfg_valid) begin
          for (k = 0; k < 4; k = k + 1)
            active_reg[k] <= shadow_reg[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // per-region evaluation
  // ----------------------------------------------------------------
  wire [3:0] region_ok;
  wire [239:0] region_mask;
  wire [59:0] covered;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : rgn
      wire [5:0] lo = active_reg[g][`LCB_RG_LO_MSB:`LCB_RG_LO_LSB];
      wire [5:0] hi = active_reg[g][`LCB_RG_HI_MSB:`LCB_RG_HI_LSB];
      wire [1:0] mode = active_reg[g][`LCB_RG_MODE_MSB:`LCB_RG_MODE_LSB];
      wire [6:0] need = {1'b0, active_reg[g][`LCB_RG_CNT_MSB:`LCB_RG_CNT_LSB]};
      wire [6:0] width = {1'b0, hi} - {1'b0, lo} + 7'd1;
      reg [59:0] mask;
      reg [6:0] cnt;
      reg [1:0] runs;
      reg prev;
      reg hit;
      reg ok;
      integer i;

      always @* begin
        mask = 60'h0;
        cnt = 7'h0;
        runs = 2'h0;
        prev = 1'b0;
        hit = 1'b0;
        for (i = 0; i < 60; i = i + 1) begin
          mask[i] = (mode != `LCB_MODE_NONE) && (i >= lo) && (i <= hi);
          hit = mask[i] & beam_sync[i];
          cnt = cnt + {6'h0, hit};
          if (hit && !prev && runs != 2'h2)
            runs = runs + 2'h1;
          prev = hit;
        end
        case (mode)
          `LCB_MODE_FIXED: ok = (cnt == width || cnt + 7'd1 == width) && runs == 2'h1;
          `LCB_MODE_FLOAT_MON: ok = (cnt == need || cnt + 7'd1 == need) && runs == 2'h1;
          `LCB_MODE_FLOAT_FREE: ok = cnt <= need;
          default: ok = 1'b1;
        endcase
      end

      assign region_ok[g] = ok;
      assign region_mask[g*60 +: 60] = mask;
    end
  endgenerate

  assign covered = region_mask[59:0] | region_mask[119:60] | region_mask[179:120] | region_mask[239:180];

  // ----------------------------------------------------------------
  // decision
  // ----------------------------------------------------------------
  wire blank_cfg;
  wire lamp_ok;
  wire blank_ok;
  wire plain_ok;
  wire scan_ok;

  assign blank_cfg = |covered;
  assign lamp_ok = lamp_sync;
  assign blank_ok = &region_ok & ~|(beam_sync & ~covered);
  assign plain_ok = ~|beam_sync;
  // without the lamp every beam is evaluated normally
  assign scan_ok = (blank_cfg && lamp_ok) ? blank_ok : plain_ok;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      safety_output_block_closed <= 1'b0;
      lockout <= 1'b0;
      blank_led_red <= 1'b0;
    end else begin
      blank_led_red <= blank_cfg;
      // lockout holds until power is cycled
      if (blank_cfg && !lamp_ok)
        lockout <= 1'b1;
      if (lockout || (blank_cfg && !lamp_ok))
        safety_output_block_closed <= 1'b0;
      else if (scan_edge)
        safety_output_block_closed <= scan_ok;
    end
  end

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  reg upload_busy;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `LCB_OFF_STATUS: reg_rdata <= {26'h0, upload_busy, blank_cfg, lamp_ok, cfg_err_reg, lockout,
                                       safety_output_block_closed};
        `LCB_OFF_BEAMS_LO: reg_rdata <= beam_sync[31:0];
        `LCB_OFF_BEAMS_HI: reg_rdata <= {4'h0, beam_sync[59:32]};
        4'h4, 4'h5, 4'h6, 4'h7: reg_rdata <= shadow_reg[reg_addr[1:0]];
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // power-up configuration upload
  // ----------------------------------------------------------------
  reg [1:0] up_state_reg;
  reg [3:0] byte_idx_reg;
  reg [3:0] bit_idx_reg;
  reg [9:0] frame_reg;
  reg [15:0] baud_cnt_reg;
  wire [31:0] up_word;
  wire [7:0] up_byte;

  assign up_word = shadow_reg[byte_idx_reg[3:2]];
  assign up_byte = up_word[{byte_idx_reg[1:0], 3'h0} +: 8];

  always @* begin
    upload_busy = up_state_reg == UP_SEND;
  end

  // the link is sampled after the synchroniser has settled and again before each byte; plugging it in later does nothing
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_state_reg <= UP_WAIT;
      byte_idx_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      frame_reg <= 10'h3ff;
      baud_cnt_reg <= 16'h0;
      link_tx <= 1'b1;
    end else begin
      case (up_state_reg)
        UP_WAIT: begin
          baud_cnt_reg <= baud_cnt_reg + 16'h1;
          if (baud_cnt_reg == 16'h3)
            up_state_reg <= UP_CHECK;
        end
        UP_CHECK: begin
          baud_cnt_reg <= 16'h0;
          bit_idx_reg <= 4'h0;
          frame_reg <= {1'b1, up_byte, 1'b0};
          up_state_reg <= link_sync ? UP_SEND : UP_DONE;
        end
        UP_SEND: begin
          link_tx <= frame_reg[0];
          if (baud_cnt_reg == BIT_CYCLES[15:0] - 16'h1) begin
            baud_cnt_reg <= 16'h0;
            frame_reg <= {1'b1, frame_reg[9:1]};
            if (bit_idx_reg == 4'h9) begin
              bit_idx_reg <= 4'h0;
              byte_idx_reg <= byte_idx_reg + 4'h1;
              if (byte_idx_reg == 4'hf)
                up_state_reg <= UP_DONE;
              else
                up_state_reg <= UP_CHECK;
            end else begin
              bit_idx_reg <= bit_idx_reg + 4'h1;
            end
          end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h1;
          end
        end
        UP_DONE: begin
          link_tx <= 1'b1;
        end
        default: begin
          up_state_reg <= UP_DONE;
        end
      endcase
    end
  end

endmodule // lcb_blanking_eval

// ----------------------------------------------------------------
// two-stage synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------
module lcb_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // asynchronous level and its settled copy
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;

  // only the second stage is read; the first may still be metastable
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // lcb_sync2

/* File: verif/lcb_eval_sva.sv */
// port checker for the light curtain blanking evaluator
`timescale 1ns/1ps
module lcb_eval_sva #(
  parameter BIT_CYCLES = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire reset_n,
  // beams and lamp
  input wire [59:0] beam_blocked,
  input wire scan_done,
  input wire lamp_present,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // safety side
  input wire safety_output_block_closed,
  input wire lockout,
  input wire blank_led_red,
  input wire link_tx
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire cl = safety_output_block_closed;
  wire cmt = reg_wr && reg_addr == 4'h0 && reg_wdata[0];
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  lock_sticky_a: assert property (lockout |=> lockout) else $error("lockout dropped");
  lock_open_a: assert property (lockout |-> !cl) else $error("closed in lockout");
  lamp_lock_a: assert property ((blank_led_red && !lamp_present) [*4] |=> lockout)
    else $error("no lockout without lamp");
  led_commit_a: assert property ($rose(blank_led_red) |-> $past(cmt) || $past(cmt, 2) || $past(cmt, 3))
    else $error("led rose without commit");
  scan_close_a: assert property ($rose(cl) |-> $past(scan_done, 3) && !$past(scan_done, 4))
    else $error("closed off scan timing");
  scan_open_a: assert property ($fell(cl) |-> lockout || ($past(scan_done, 3) && !$past(scan_done, 4)))
    else $error("opened off scan timing");
  free_beam_a: assert property ($rose(scan_done) && !blank_led_red && |beam_blocked |-> ##3 !cl)
    else $error("blocked beam kept closed");
  tx_start_a: assert property ($fell(link_tx) |-> (!link_tx) [*4]) else $error("short link bit");
  cover property ($rose(cl));
  cover property ($rose(lockout));
  cover property ($fell(link_tx));
endmodule // lcb_eval_sva

/* File: verif/lcb_beam_model.sv */
// beam receiver array model: presents a pattern, then marks the end of the scan
`timescale 1ns/1ps
module lcb_beam_model (
  // clock
  input wire sys_clk,
  // beam array side
  output logic [59:0] beam_blocked,
  output logic scan_done
);
  // ----
  // scan driver
  // ----
  initial begin
    beam_blocked = 60'h0;
    scan_done = 1'b0;
  end
  // pattern settles 5 cycles before the scan edge and holds until the next scan
  task automatic scan(input logic [59:0] pat);
    @(posedge sys_clk);
    beam_blocked <= pat;
    repeat (5) @(posedge sys_clk);
    scan_done <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scan_done <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule // lcb_beam_model

/* File: verif/test_light_curtain_blanking_eval.sv */
// self-checking bench for the light curtain blanking evaluator
`timescale 1ns/1ps
`include "lcb_regs.vh"
module test_light_curtain_blanking_eval;
  // ----
  // harness
  // ----
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic lamp_present = 1'b1;
  logic link_attached = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [59:0] beam_blocked;
  wire scan_done;
  wire [31:0] reg_rdata;
  wire closed;
  wire lockout;
  wire led;
  wire link_tx;
  int fail_count = 0;
  int checks = 0;
  always #5 sys_clk = ~sys_clk;
  lcb_beam_model i_beam (.sys_clk(sys_clk), .beam_blocked(beam_blocked), .scan_done(scan_done));
  lcb_blanking_eval #(.BIT_CYCLES(4)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .beam_blocked(beam_blocked), .scan_done(scan_done), .lamp_present(lamp_present),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .safety_output_block_closed(closed), .lockout(lockout),
    .blank_led_red(led), .link_attached(link_attached), .link_tx(link_tx));
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [59:0] m(input int lo, input int hi);
    return ((60'h1 << (hi - lo + 1)) - 60'h1) << lo;
  endfunction
  function automatic logic [31:0] rg(input int lo, input int hi, input logic [1:0] md, input int c);
    return {2'h0, 6'(c), 6'h0, md, 2'h0, 6'(hi), 2'h0, 6'(lo)};
  endfunction
  task automatic cfg(input logic [31:0] v);
    wr(`LCB_OFF_REGION0, v);
    wr(`LCB_OFF_CTRL, 32'h1);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic sc(input logic [59:0] p, input logic e);
    i_beam.scan(p);
    #1 ck("closed", 32'(e), 32'(closed));
  endtask
  task automatic rs(input int b, input logic e);
    logic [31:0] s;
    rd(`LCB_OFF_STATUS, s);
    ck("status bit", 32'(e), 32'(s[b]));
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_upload;
    int i, j, t;
    logic [31:0] s;
    logic [127:0] img;
    img = {96'h0, rg(10, 15, `LCB_MODE_FIXED, 0)};
    #1 ck("outputs", 32'h1, 32'({closed, lockout, led, link_tx}));
    wr(`LCB_OFF_REGION0, img[31:0]);
    for (i = 0; i < 16; i++) begin
      t = 0;
      while (link_tx !== 1'b0 && t < 400) begin
        @(posedge sys_clk);
        #1 t++;
      end
      repeat (2) @(posedge sys_clk);
      for (j = 1; j < 10; j++) begin
        repeat (4) @(posedge sys_clk);
        #1 ck("tx bit", 32'((j == 9) ? 1'b1 : img[i * 8 + j - 1]), 32'(link_tx));
      end
    end
    rd(`LCB_OFF_STATUS, s);
    ck("status", 32'h8, s);
  endtask
  task automatic t_regs;
    logic [31:0] s;
    wr(4'h4, 32'hffffffff);
    rd(4'h4, s);
    ck("region0", 32'h3f033f3f, s);
    wr(4'hf, 32'hffffffff);
    rd(4'hf, s);
    ck("unmapped", 32'h0, s);
    wr(4'h4, 32'h0);
  endtask
  task automatic t_fixed;
    sc(60'h0, 1'b1);
    sc(m(5, 5), 1'b0);
    cfg(rg(10, 15, `LCB_MODE_FIXED, 0));
    ck("led", 32'h1, 32'(led));
    rs(4, 1'b1);
    sc(m(10, 15), 1'b1);
    sc(m(10, 14), 1'b1);
    sc(m(11, 15), 1'b1);
    sc(m(12, 15), 1'b0);
    sc(m(11, 16), 1'b0);
    sc(m(9, 14), 1'b0);
    sc(m(10, 12) | m(14, 15), 1'b0);
    sc(m(10, 15) | m(40, 40), 1'b0);
    cfg(rg(20, 20, `LCB_MODE_FIXED, 0));
    rs(2, 1'b1);
    sc(m(10, 15), 1'b1);
    wr(4'h5, rg(14, 30, `LCB_MODE_FLOAT_MON, 6));
    cfg(rg(10, 15, `LCB_MODE_FIXED, 0));
    rs(2, 1'b1);
    wr(4'h5, 32'h0);
  endtask
  task automatic t_float;
    logic [31:0] s;
    cfg(rg(0, 29, `LCB_MODE_FLOAT_MON, 6));
    rs(2, 1'b0);
    sc(m(10, 15), 1'b1);
    sc(m(20, 24), 1'b1);
    sc(m(20, 23), 1'b0);
    sc(m(10, 16), 1'b0);
    sc(m(10, 15) | m(20, 20), 1'b0);
    sc(m(10, 14) | m(20, 20), 1'b0);
    sc(m(10, 12) | m(14, 15), 1'b0);
    sc(m(10, 15) | m(40, 40), 1'b0);
    rd(`LCB_OFF_BEAMS_LO, s);
    ck("beams lo", 32'h0000fc00, s);
    rd(`LCB_OFF_BEAMS_HI, s);
    ck("beams hi", 32'h00000100, s);
    cfg(rg(0, 29, `LCB_MODE_FLOAT_FREE, 6));
    sc(60'h0, 1'b1);
    sc(m(2, 2) | m(5, 6) | m(9, 9), 1'b1);
    sc(m(0, 5), 1'b1);
    sc(m(0, 6), 1'b0);
  endtask
  task automatic t_lamp;
    @(posedge sys_clk);
    lamp_present <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 ck("lock", 32'h2, 32'({lockout, closed}));
    sc(60'h0, 1'b0);
  endtask
  task automatic t_nolink;
    int i;
    logic lo;
    lo = 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    link_attached <= 1'b0;
    lamp_present <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      #1 lo = lo | !link_tx;
    end
    ck("tx idle", 32'h0, 32'(lo));
    ck("lock", 32'h0, 32'(lockout));
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_upload;
    t_regs;
    t_fixed;
    t_float;
    t_lamp;
    t_nolink;
    wrap_up;
  end
  // the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    wrap_up;
  end
endmodule // test_light_curtain_blanking_eval
bind lcb_blanking_eval lcb_eval_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
  .beam_blocked(beam_blocked), .scan_done(scan_done), .lamp_present(lamp_present), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .safety_output_block_closed(safety_output_block_closed), .lockout(lockout),
  .blank_led_red(blank_led_red), .link_tx(link_tx));
